//--- rtl/tbaf_pkg.sv
package tbaf_pkg;

    // ------------------------------------------------------------
    // command codes and frame fields
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_REQUEST = 8'h05;
    localparam logic [3:0] CMD_SLOT_LOW = 4'h5;
    localparam logic [7:0] CMD_HALT = 8'h50;
    localparam logic [7:0] CMD_ATTRIB = 8'h1D;
    localparam logic [7:0] CMD_DESELECT = 8'hCA;
    localparam int PARAM_WAKE_BIT = 3;
    localparam int PARAM_SLOTS_MSB = 2;
    localparam logic [2:0] SLOTS_CODE_MAX = 3'h4;
    localparam logic [7:0] AFI_ANY = 8'h00;
    localparam logic [3:0] AFI_LOW_WILD = 4'h0;
    localparam int PUPI_BITS = 32;

    // ------------------------------------------------------------
    // reset values and lfsr feedback taps
    // ------------------------------------------------------------
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [3:0] SLOT_RST = 4'h0;
    localparam logic [3:0] CID_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT_SLOT = 3'h1,
        ST_READY = 3'h3,
        ST_ACTIVE = 3'h2,
        ST_HALT = 3'h6
    } tbaf_state_t;

    typedef enum logic [1:0] {
        TX_ATQB = 2'h0,
        TX_HALT_ACK = 2'h1,
        TX_ATTRIB_ACK = 2'h2,
        TX_DESEL_ACK = 2'h3
    } tbaf_tx_kind_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] afi;
        logic [7:0] param;
        logic [31:0] pupi;
        logic [3:0] cid;
        logic crc_ok;
    } tbaf_frame_t;

    typedef struct packed {
        tbaf_tx_kind_t kind;
        logic [31:0] pupi;
    } tbaf_tx_t;

    typedef struct packed {
        tbaf_state_t state;
        logic [3:0] slot;
        logic [3:0] cid;
        logic [15:0] lfsr;
        logic [2:0] rx_sync;
        logic tx_tog;
        tbaf_tx_t tx;
    } tbaf_core_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic rx_tog;
        tbaf_frame_t frame;
        logic [2:0] tx_sync;
        logic tx_start;
        tbaf_tx_t tx;
    } tbaf_link_t;

endpackage : tbaf_pkg

//--- rtl/tbaf_anticollision.sv
`timescale 1ns/1ps

// Function
// R1: after power-up the card sits in idle silently; only passing requests count.
// R2: passing request moves idle, halt, ready to waiting when slots and draw not 1.
// R3: waiting for a slot marker ignores all but requests and slot markers.
// R4: waiting goes to ready on matching slot marker or request bypass.
// R5: request with failing family id sends waiting or ready back to idle.
// R6: every entry into ready sends one answer-to-request frame.
// R7: ready reacts only to request, wake-up, attrib and halt frames.
// R8: ready goes active on attrib, halt on halt frame, both with own pupi.
// R9: active deselect with own card id goes to halt; halt entry confirms.
// R10: halt reacts only to wake-up; goes idle, ready or waiting.
// R11: active entered only from ready by matching attrib, with confirmation.
// R12: card id of four bits from attrib is stored and matched while active.
// R13: request frame is command 05h, family id, parameter, crc.
// R14: request family id 00h is accepted whatever the own family id.
// R15: low nibble zero, nonzero byte: accept on matching high nibble only.
// R16: any other family id must match all eight bits.
// R17: parameter bit 4 zero means request, one means wake-up.
// R18: parameter bits 3..1 give 1,2,4,8,16 slots; higher codes reserved.
// R19: with one slot every accepting card goes straight to ready.
// R20: with more slots a fresh random slot 1..N is drawn per request.
// R21: a card drawing slot 1 answers the request at once; a card already in ready stays there silently.
// R22: reader sends slot markers only after N above one, at most N-1.
// R23: slot marker is one byte, low nibble 0101, high nibble slot.
// R24: marker nibble plus one is the slot number, any order.
// R25: card reaching ready through its slot marker answers that marker.
// R26: pupi reported and matched is the low four bytes of the uid.
// R27: frames with crc error or reserved slot code are ignored.
// R28: random slot is held until the next accepted request.
module tbaf_anticollision (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rf_clk,
    input wire logic [7:0] own_afi,
    input wire logic [63:0] uid,
    input wire logic rx_valid,
    input wire tbaf_pkg::tbaf_frame_t rx_frame,
    output logic tx_start,
    output tbaf_pkg::tbaf_tx_t tx_info,
    output tbaf_pkg::tbaf_state_t state,
    output logic [3:0] rand_slot,
    output logic [3:0] card_id
);
    import tbaf_pkg::*;

    tbaf_core_t c_q;
    tbaf_core_t c_d;
    tbaf_link_t l_q;
    tbaf_link_t l_d;

    // ------------------------------------------------------------
    // frame decode, core domain
    // ------------------------------------------------------------
    // frame word is held in the link domain until the next frame;
    // reader turnaround keeps it stable far longer than the sync
    tbaf_frame_t f;
    logic rx_ev;
    logic is_req;
    logic is_wake;
    logic is_marker;
    logic slots_bad;
    logic afi_ok;
    logic [4:0] n_val;
    logic [3:0] draw;
    logic pupi_ok;
    tbaf_state_t req_go;
    tbaf_state_t go_state;
    logic go_tx;
    tbaf_tx_kind_t go_kind;
    logic take_slot;
    logic take_cid;

    assign f = l_q.frame;
    assign rx_ev = c_q.rx_sync[2] ^ c_q.rx_sync[1];
    assign is_req = f.cmd == CMD_REQUEST; // R13
    assign is_wake = f.param[PARAM_WAKE_BIT]; // R17
    assign is_marker = (f.cmd[3:0] == CMD_SLOT_LOW) && !is_req; // R23
    assign slots_bad = is_req
        && (f.param[PARAM_SLOTS_MSB:0] > SLOTS_CODE_MAX); // R18 R27
    assign pupi_ok = f.pupi == uid[PUPI_BITS-1:0]; // R26

    always_comb begin
        if (f.afi == AFI_ANY) begin
            afi_ok = 1'b1; // R14
        end else if (f.afi[3:0] == AFI_LOW_WILD) begin
            afi_ok = f.afi[7:4] == own_afi[7:4]; // R15
        end else begin
            afi_ok = f.afi == own_afi; // R16
        end
    end

    // draw 0 stands for slot 1, so a one-slot request always bypasses
    assign n_val = 5'h01 << f.param[PARAM_SLOTS_MSB:0];
    assign draw = c_q.lfsr[3:0] & 4'(n_val - 5'h01); // R20
    assign req_go = !afi_ok ? ST_IDLE // R5
        : (draw == SLOT_RST) ? ST_READY // R19 R21
        : ST_WAIT_SLOT; // R2

    // ------------------------------------------------------------
    // transition table
    // ------------------------------------------------------------
    always_comb begin
        go_state = c_q.state;
        go_tx = 1'b0;
        go_kind = TX_ATQB;
        take_slot = 1'b0;
        take_cid = 1'b0;
        unique case (c_q.state)
            ST_IDLE: begin
                if (is_req) begin // R1
                    go_state = req_go;
                    take_slot = afi_ok;
                end
            end
            ST_WAIT_SLOT: begin
                if (is_req) begin // R3
                    go_state = req_go;
                    take_slot = afi_ok;
                end else if (is_marker && f.cmd[7:4] == c_q.slot) begin
                    go_state = ST_READY; // R4 R24 R25 R28
                end
            end
            ST_READY: begin
                if (is_req) begin // R7
                    go_state = req_go;
                    take_slot = afi_ok;
                end else if (f.cmd == CMD_HALT && pupi_ok) begin
                    go_state = ST_HALT; // R8
                    go_kind = TX_HALT_ACK;
                end else if (f.cmd == CMD_ATTRIB && pupi_ok) begin
                    go_state = ST_ACTIVE; // R8 R11
                    go_kind = TX_ATTRIB_ACK;
                    take_cid = 1'b1;
                end
            end
            ST_HALT: begin
                if (is_req && is_wake) begin // R10
                    go_state = req_go;
                    take_slot = afi_ok;
                end
            end
            ST_ACTIVE: begin
                if (f.cmd == CMD_DESELECT && f.cid == c_q.cid) begin
                    go_state = ST_HALT; // R9 R12
                    go_kind = TX_DESEL_ACK;
                end
            end
            default: begin
                go_state = ST_IDLE;
            end
        endcase
        // every entry into ready, halt or active answers the reader
        go_tx = (go_state != c_q.state) && (go_state == ST_READY
            || go_state == ST_HALT || go_state == ST_ACTIVE); // R6 R9 R11
    end

    // ------------------------------------------------------------
    // core domain state
    // ------------------------------------------------------------
    always_comb begin
        c_d = c_q;
        c_d.rx_sync = {c_q.rx_sync[1:0], l_q.rx_tog};
        // free running, so the draw depends on request arrival time
        c_d.lfsr = c_q.lfsr[0] ? ((c_q.lfsr >> 1) ^ LFSR_TAPS)
            : (c_q.lfsr >> 1);
        if (rx_ev && f.crc_ok && !slots_bad) begin // R27
            c_d.state = go_state;
            if (take_slot) begin
                c_d.slot = draw; // R20 R28
            end
            if (take_cid) begin
                c_d.cid = f.cid; // R12
            end
            if (go_tx) begin
                c_d.tx_tog = ~c_q.tx_tog;
                c_d.tx.kind = go_kind;
                c_d.tx.pupi = uid[PUPI_BITS-1:0]; // R26
            end
        end
        if (!nrst) begin
            c_d.state = ST_IDLE; // R1
            c_d.slot = SLOT_RST;
            c_d.cid = CID_RST;
            c_d.lfsr = LFSR_SEED;
            c_d.rx_sync = 3'h0;
            c_d.tx_tog = 1'b0;
            c_d.tx.kind = TX_ATQB;
            c_d.tx.pupi = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        c_q <= c_d;
    end

    // ------------------------------------------------------------
    // link domain, rf carrier clock
    // ------------------------------------------------------------
    // reset reaches this domain through its own two-stage sync
    always_comb begin
        l_d = l_q;
        l_d.rst_sync = {l_q.rst_sync[0], nrst};
        l_d.tx_sync = {l_q.tx_sync[1:0], c_q.tx_tog};
        l_d.tx_start = 1'b0;
        if (rx_valid) begin
            l_d.frame = rx_frame;
            l_d.rx_tog = ~l_q.rx_tog;
        end
        if (l_q.tx_sync[2] ^ l_q.tx_sync[1]) begin
            l_d.tx_start = 1'b1; // R6
            l_d.tx = c_q.tx;
        end
        if (!l_q.rst_sync[1]) begin
            l_d.rx_tog = 1'b0;
            l_d.frame = '0;
            l_d.tx_sync = 3'h0;
            l_d.tx_start = 1'b0;
            l_d.tx.kind = TX_ATQB;
            l_d.tx.pupi = '0;
        end
    end

    always_ff @(posedge rf_clk) begin
        l_q <= l_d;
    end

    assign tx_start = l_q.tx_start;
    assign tx_info = l_q.tx;
    assign state = c_q.state;
    assign rand_slot = c_q.slot;
    assign card_id = c_q.cid;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic ok_ev;
    assign ok_ev = rx_ev && f.crc_ok && !slots_bad;

    a_reset_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(nrst) |-> c_q.state == ST_IDLE) // R1
        else $error("state not idle after reset");

    a_bad_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_ev && !(f.crc_ok && !slots_bad)
        |=> $stable(c_q.state) && $stable(c_q.tx_tog)) // R27
        else $error("bad frame changed state");

    a_ready_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.state) && c_q.state == ST_READY
        |-> $changed(c_q.tx_tog) && c_q.tx.kind == TX_ATQB) // R6
        else $error("ready entered without atqb");

    a_halt_confirm: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.state) && c_q.state == ST_HALT |-> $changed(c_q.tx_tog)
        && (c_q.tx.kind == TX_HALT_ACK || c_q.tx.kind == TX_DESEL_ACK)) // R9
        else $error("halt entered without confirm");

    a_active_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.state) && c_q.state == ST_ACTIVE
        |-> $past(c_q.state) == ST_READY
        && c_q.tx.kind == TX_ATTRIB_ACK && c_q.cid == $past(f.cid)) // R11
        else $error("active entered illegally");

    a_slot_match: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && c_q.state == ST_WAIT_SLOT && is_marker
        && f.cmd[7:4] == c_q.slot |=> c_q.state == ST_READY) // R4
        else $error("matching slot marker missed");

    a_wait_slot: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.state) && c_q.state == ST_WAIT_SLOT
        |-> c_q.slot != SLOT_RST) // R2
        else $error("waiting with slot one");

    a_any_afi: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && is_req && f.afi == AFI_ANY && c_q.state != ST_HALT
        && c_q.state != ST_ACTIVE
        |=> c_q.state == ST_READY || c_q.state == ST_WAIT_SLOT) // R14
        else $error("wildcard afi not accepted");

    a_ready_ignore: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_ev && c_q.state == ST_READY && !is_req && f.cmd != CMD_HALT
        && f.cmd != CMD_ATTRIB |=> $stable(c_q.state)) // R7
        else $error("ready reacted to other frame");

    a_halt_wake: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_ev && c_q.state == ST_HALT && !(is_req && is_wake)
        |=> c_q.state == ST_HALT) // R10
        else $error("halt left without wake-up");

    a_tx_pulse: assert property (@(posedge rf_clk)
        disable iff (!l_q.rst_sync[1])
        l_q.tx_start |=> !l_q.tx_start) // R6
        else $error("tx start longer than one cycle");

    a_wait_ignore: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_ev && c_q.state == ST_WAIT_SLOT && !is_req && !is_marker
        |=> $stable(c_q.state)) // R3
        else $error("waiting reacted to other frame");

    a_wait_afi_fail: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && is_req && c_q.state == ST_WAIT_SLOT
        && f.afi[3:0] != AFI_LOW_WILD && f.afi != own_afi
        |=> c_q.state == ST_IDLE) // R5
        else $error("failing afi did not return to idle");

    a_full_afi: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && is_req && c_q.state == ST_READY
        && f.afi[3:0] != AFI_LOW_WILD && f.afi != own_afi
        |=> c_q.state == ST_IDLE) // R16
        else $error("full afi mismatch accepted");

    a_high_nibble: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && is_req && c_q.state == ST_READY && f.afi != AFI_ANY
        && f.afi[3:0] == AFI_LOW_WILD && f.afi[7:4] != own_afi[7:4]
        |=> c_q.state == ST_IDLE) // R15
        else $error("family nibble mismatch accepted");

    a_one_slot: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && is_req && f.afi == AFI_ANY
        && f.param[PARAM_SLOTS_MSB:0] == '0
        && (c_q.state == ST_IDLE || c_q.state == ST_WAIT_SLOT)
        |=> c_q.state == ST_READY) // R19
        else $error("one slot request not ready");

    a_slot_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        c_q.state == ST_WAIT_SLOT && !(ok_ev && is_req)
        |=> $stable(c_q.slot)) // R28
        else $error("random slot changed while waiting");

    a_draw_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.slot)
        |-> ({1'b0, c_q.slot} >> f.param[PARAM_SLOTS_MSB:0]) == 5'h00) // R20
        else $error("random slot out of range");

    a_cid_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        c_q.state == ST_ACTIVE |=> $stable(c_q.cid)) // R12
        else $error("card id changed while active");

    a_pupi_tx: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.tx_tog) |-> c_q.tx.pupi == uid[PUPI_BITS-1:0]) // R26
        else $error("answer carries wrong pupi");

    a_marker_miss: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && c_q.state == ST_WAIT_SLOT && is_marker
        && f.cmd[7:4] != c_q.slot |=> c_q.state == ST_WAIT_SLOT) // R23
        else $error("other slot marker left waiting");

    a_idle_exit: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(c_q.state) && $past(c_q.state) == ST_IDLE
        |-> $past(is_req)) // R13
        else $error("idle left without request");

    a_wake_only: assert property (@(posedge ref_clk) disable iff (!nrst)
        ok_ev && c_q.state == ST_HALT && is_req && !is_wake
        |=> c_q.state == ST_HALT) // R17
        else $error("plain request woke halted card");

    c_wait_then_ready: cover property (@(posedge ref_clk) disable iff (!nrst)
        c_q.state == ST_WAIT_SLOT ##1 c_q.state == ST_READY);
    c_go_active: cover property (@(posedge ref_clk) disable iff (!nrst)
        c_q.state == ST_READY ##1 c_q.state == ST_ACTIVE);
    c_deselect: cover property (@(posedge ref_clk) disable iff (!nrst)
        c_q.state == ST_ACTIVE ##1 c_q.state == ST_HALT);
    c_wake_halt: cover property (@(posedge ref_clk) disable iff (!nrst)
        c_q.state == ST_HALT ##1 c_q.state != ST_HALT);

endmodule : tbaf_anticollision

//--- verification/tbaf_reader.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// reader model: each decoded frame is one rx_valid pulse lasting one rf_clk cycle
// ------------------------------------------------------------
module tbaf_reader (
    input wire logic rf_clk,
    output logic rx_valid,
    output tbaf_pkg::tbaf_frame_t rx_frame
);
    import tbaf_pkg::*;

    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
    end

    // idle lines show the inverse so a stale frame cannot pass for new
    task automatic send(input tbaf_frame_t f);
        @(posedge rf_clk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge rf_clk);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
    endtask : send

    task automatic req(input logic [7:0] afi, input logic wake,
                       input logic [2:0] code, input logic crc);
        send({CMD_REQUEST, afi, {4'h0, wake, code}, 32'h0, 4'h0, crc});
    endtask : req

    // caller marks at most n-1 times after n above one, plus one marker in ready after a one-slot request
    task automatic mark(input logic [3:0] nib);
        send({nib, CMD_SLOT_LOW, 16'h0, 32'h0, 4'h0, 1'b1});
    endtask : mark

    task automatic cmd(input logic [7:0] c, input logic [31:0] pupi,
                       input logic [3:0] cid);
        send({c, 16'h0, pupi, cid, 1'b1});
    endtask : cmd
endmodule : tbaf_reader

//--- verification/tbaf_anticollision_test.sv
`timescale 1ns/1ps

module tbaf_anticollision_test;
    import tbaf_pkg::*;

    logic ref_clk;
    logic rf_clk;
    logic nrst;
    logic rx_valid;
    logic tx_start;
    logic [7:0] own_afi;
    logic [63:0] uid;
    tbaf_frame_t rx_frame;
    tbaf_tx_t tx_info;
    tbaf_state_t state;
    logic [3:0] rand_slot;
    logic [3:0] card_id;
    tbaf_tx_t exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    int stray = 0;
    int seed = 32'hB21CE30D;
    int i;
    bit maybe = 1'b0;
    logic [31:0] r;
    logic [31:0] pupi;
    logic [3:0] cid;
    logic [3:0] nib;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        rf_clk = 1'b0;
        #1.7;
        forever #3 rf_clk = ~rf_clk;
    end

    tbaf_anticollision dut (.ref_clk(ref_clk), .nrst(nrst), .rf_clk(rf_clk),
        .own_afi(own_afi), .uid(uid), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_start(tx_start), .tx_info(tx_info),
        .state(state), .rand_slot(rand_slot), .card_id(card_id));

    tbaf_reader rdr (.rf_clk(rf_clk), .rx_valid(rx_valid),
        .rx_frame(rx_frame));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // frames must be spaced; this also covers the answer latency
    task automatic settle(input tbaf_state_t s);
        repeat (24) @(posedge ref_clk);
        check(state, s);
        check(exp_q.size(), 0);
    endtask : settle

    // ------------------------------------------------------------
    // response watcher
    // ------------------------------------------------------------
    always @(posedge rf_clk) begin
        if (tx_start === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(tx_info, exp_q.pop_front());
            end else if (maybe) begin
                stray++;
                check(tx_info, {TX_ATQB, pupi});
            end else begin
                check(tx_start, 1'b0);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("ERROR at %0t: seen %0h expected %0h", $time, 0, 1);
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        own_afi = 8'h00;
        uid = 64'h0;
        r = $random(seed);
        @(posedge ref_clk);
        // bit 0 of both nibbles set: nibble flips by 2 never give 00h
        own_afi <= {r[7:5], 1'b1, r[3:1], 1'b1};
        uid <= {$random(seed), $random(seed)};
        cid = r[11:8];
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        settle(ST_IDLE);
        pupi = uid[31:0];
        check(rand_slot, SLOT_RST);
        check(card_id, CID_RST);
        rdr.req(AFI_ANY, 1'b0, 3'h0, 1'b0);
        settle(ST_IDLE);
        rdr.req(AFI_ANY, 1'b0, 3'h5, 1'b1);
        settle(ST_IDLE);
        rdr.req(AFI_ANY, 1'b0, 3'h6, 1'b1);
        settle(ST_IDLE);
        rdr.req(own_afi ^ 8'h02, 1'b0, 3'h0, 1'b1);
        settle(ST_IDLE);
        rdr.req({own_afi[7:4] ^ 4'h2, AFI_LOW_WILD}, 1'b0, 3'h0, 1'b1);
        settle(ST_IDLE);
        rdr.cmd(CMD_ATTRIB, pupi, cid);
        settle(ST_IDLE);
        exp_q.push_back({TX_ATQB, pupi});
        rdr.req({own_afi[7:4], AFI_LOW_WILD}, 1'b0, 3'h0, 1'b1);
        settle(ST_READY);
        rdr.req(own_afi, 1'b0, 3'h0, 1'b1);
        settle(ST_READY);
        rdr.req({own_afi[7:4] ^ 4'h2, AFI_LOW_WILD}, 1'b0, 3'h0, 1'b1);
        settle(ST_IDLE);
        exp_q.push_back({TX_ATQB, pupi});
        rdr.req(AFI_ANY, 1'b0, 3'h0, 1'b1);
        settle(ST_READY);
        rdr.mark(4'h1);
        settle(ST_READY);
        rdr.cmd(CMD_DESELECT, pupi, CID_RST);
        settle(ST_READY);
        rdr.cmd(CMD_HALT, ~pupi, CID_RST);
        settle(ST_READY);
        exp_q.push_back({TX_ATTRIB_ACK, pupi});
        rdr.cmd(CMD_ATTRIB, pupi, cid);
        settle(ST_ACTIVE);
        check(card_id, cid);
        rdr.req(AFI_ANY, 1'b1, 3'h0, 1'b1);
        settle(ST_ACTIVE);
        rdr.cmd(CMD_DESELECT, 32'h0, cid ^ 4'h1);
        settle(ST_ACTIVE);
        exp_q.push_back({TX_DESEL_ACK, pupi});
        rdr.cmd(CMD_DESELECT, 32'h0, cid);
        settle(ST_HALT);
        rdr.req(AFI_ANY, 1'b0, 3'h0, 1'b1);
        settle(ST_HALT);
        exp_q.push_back({TX_ATQB, pupi});
        rdr.req(AFI_ANY, 1'b1, 3'h0, 1'b1);
        settle(ST_READY);
        exp_q.push_back({TX_HALT_ACK, pupi});
        rdr.cmd(CMD_HALT, pupi, CID_RST);
        settle(ST_HALT);
        rdr.req(own_afi ^ 8'h02, 1'b1, 3'h0, 1'b1);
        settle(ST_IDLE);
        $display("test state walk done");
        for (i = 1; i <= 4; i++) begin
            // the draw is unknown until it shows on rand_slot
            maybe = 1'b1;
            stray = 0;
            rdr.req(AFI_ANY, 1'b0, i[2:0], 1'b1);
            repeat (24) @(posedge ref_clk);
            maybe = 1'b0;
            if (rand_slot === 4'h0) begin
                check(state, ST_READY);
                check(stray, 1);
            end else begin
                check(state, ST_WAIT_SLOT);
                check(stray, 0);
                check(rand_slot >> i, 0);
                nib = rand_slot;
                if (nib > 4'h1) begin
                    rdr.mark(nib - 4'h1);
                    settle(ST_WAIT_SLOT);
                end
                rdr.cmd(CMD_HALT, pupi, CID_RST);
                settle(ST_WAIT_SLOT);
                check(rand_slot, nib);
                exp_q.push_back({TX_ATQB, pupi});
                rdr.mark(nib);
                settle(ST_READY);
            end
            rdr.req(own_afi ^ 8'h02, 1'b0, 3'h0, 1'b1);
            settle(ST_IDLE);
            $display("test slot code %0d done", i);
        end
        complete_run();
    end
endmodule : tbaf_anticollision_test
